// ===== logic/cpce_engine.sv
// current and power calculation engine with byte-wide register port
`timescale 1ns/1ps
`include "cpce_regs.svh"

module cpce_engine (
  input wire logic mclk,                 // 40 MHz core clock
  input wire logic rst,                  // synchronous, active high
  input wire logic meas_valid,           // one-cycle pulse, new conversion
  input wire cpce_pkg::cpce_meas_t meas, // conversion values with meas_valid
  input wire logic ptr_load,             // one-cycle pulse, load pointer
  input wire logic [7:0] ptr_byte,       // pointer value with ptr_load
  input wire logic wr_stb,               // one-cycle pulse, data byte written
  input wire logic [7:0] wr_byte,        // data byte with wr_stb
  input wire logic rd_stb,               // one-cycle pulse, data byte read
  output logic [7:0] rd_byte,            // read byte, valid the cycle after rd_stb
  output logic [15:0] cfg_word           // configuration word for the converter
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [7:0] ptr_ff;                // register pointer, kept across reads
  logic [15:0] cfg_ff;               // configuration register
  logic [15:0] cal_ff;               // calibration register
  logic cal_set_ff;                  // calibration written since reset
  logic [7:0] wr_hi_ff;              // first (upper) byte of a write
  logic wr_phase_ff;                 // 1 once upper byte captured
  logic rd_phase_ff;                 // 1 once upper byte sent
  logic [7:0] rd_byte_ff;            // read data flop
  cpce_pkg::cpce_result_t res_ff;    // result words

  // --------------------------------------------------------------------------
  // arithmetic
  // --------------------------------------------------------------------------
  logic signed [32:0] cur_prod;      // shunt times calibration
  logic signed [32:0] cur_quot;
  logic [15:0] cur_calc;
  logic signed [32:0] pwr_prod;      // current times bus
  logic signed [32:0] pwr_quot;
  logic [15:0] pwr_calc;
  logic [15:0] bus_calc;
  logic signed [32:0] shunt_ext;     // shunt, sign-extended
  logic signed [32:0] cal_ext;       // calibration, zero-extended
  logic signed [32:0] cur_ext;       // new current, sign-extended
  logic signed [32:0] bus_ext;       // bus result, zero-extended

  // two measured inputs only
  // calibration is zero-extended so it stays a positive scale factor
  // operands widened first so the product never wraps in a narrow context
  // widest case, -32768 x 65535, still fits 33 signed bits
  assign shunt_ext = {{17{meas.shunt[15]}}, meas.shunt};
  assign cal_ext = {17'h0, cal_ff};
  assign cur_prod = shunt_ext * cal_ext;
  // truncating divide
  // signed divide truncates toward zero, so negative current keeps its magnitude
  assign cur_quot = cur_prod / `CPCE_CUR_DIV;
  assign cur_calc = cur_quot[15:0];
  assign bus_calc = {1'b0, meas.bus[14:0]};
  // power from new current
  // the 20000 divisor fixes power count at 25 current counts
  // limitation: current is read back as signed 16 bits, so a wrapped current wraps power too
  assign cur_ext = {{17{cur_calc[15]}}, cur_calc};
  assign bus_ext = {17'h0, bus_calc};
  assign pwr_prod = cur_ext * bus_ext;
  assign pwr_quot = pwr_prod / `CPCE_PWR_DIV;
  assign pwr_calc = pwr_quot[15:0];

  // --------------------------------------------------------------------------
  // register port decode
  // --------------------------------------------------------------------------
  logic wr_commit;                   // second byte of a write arrives
  logic wr_cfg;
  logic wr_cal;
  logic rd_take;                     // a read byte is served
  logic [15:0] sel_word;             // word under the pointer

  // a pointer load in the same cycle wins: the data byte belongs to the old frame
  assign wr_commit = wr_stb & wr_phase_ff & ~ptr_load;
  assign wr_cfg = wr_commit & (ptr_ff == `CPCE_PTR_CONFIG);
  assign wr_cal = wr_commit & (ptr_ff == `CPCE_PTR_CAL);
  // a read strobe clashing with a pointer load is dropped as well
  assign rd_take = rd_stb & ~ptr_load;

  // unmapped pointers read as zero
  assign sel_word = (ptr_ff == `CPCE_PTR_CONFIG) ? cfg_ff :
                    (ptr_ff == `CPCE_PTR_SENSE) ? res_ff.sense :
                    (ptr_ff == `CPCE_PTR_SUPPLY) ? res_ff.supply :
                    (ptr_ff == `CPCE_PTR_POWER) ? res_ff.power :
                    (ptr_ff == `CPCE_PTR_CURRENT) ? res_ff.current :
                    (ptr_ff == `CPCE_PTR_CAL) ? cal_ff : `CPCE_WORD_RST;

  // --------------------------------------------------------------------------
  // pointer and byte phases
  // --------------------------------------------------------------------------
  // pointer load restarts both byte phases
  always_ff @(posedge mclk) begin
    if (rst) begin
      ptr_ff <= 8'h00;
      wr_phase_ff <= 1'b0;
      rd_phase_ff <= 1'b0;
      wr_hi_ff <= 8'h00;
    end else if (ptr_load) begin
      ptr_ff <= ptr_byte;
      wr_phase_ff <= 1'b0;
      rd_phase_ff <= 1'b0;
    end else begin
      if (wr_stb) begin
        wr_phase_ff <= ~wr_phase_ff;
        wr_hi_ff <= wr_byte;
      end
      if (rd_take) begin
        rd_phase_ff <= ~rd_phase_ff;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  // upper byte first on read
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_byte_ff <= 8'h00;
    end else if (rd_take) begin
      rd_byte_ff <= rd_phase_ff ? sel_word[7:0] : sel_word[15:8];
    end
  end

  // --------------------------------------------------------------------------
  // writable registers
  // --------------------------------------------------------------------------
  // default config converts continuously
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_ff <= `CPCE_CONFIG_RST;
      cal_ff <= `CPCE_WORD_RST;
      cal_set_ff <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= {wr_hi_ff, wr_byte};
      end
      if (wr_cal) begin
        cal_ff <= {wr_hi_ff, wr_byte};
        cal_set_ff <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // result registers
  // --------------------------------------------------------------------------
  // voltages always update; current and power only once calibrated
  always_ff @(posedge mclk) begin
    if (rst) begin
      res_ff <= '0;
    end else if (meas_valid) begin
      res_ff.sense <= meas.shunt;
      res_ff.supply <= bus_calc;
      if (cal_set_ff) begin
        res_ff.current <= cur_calc;
        res_ff.power <= pwr_calc;
      end
    end
  end

  assign rd_byte = rd_byte_ff;
  assign cfg_word = cfg_ff;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_CUR_ZERO_UNCAL: assert property (!cal_set_ff |-> res_ff.current == 16'h0000)
    else $error("current nonzero before calibration");
  AST_PWR_ZERO_UNCAL: assert property (!cal_set_ff |-> res_ff.power == 16'h0000)
    else $error("power nonzero before calibration");
  AST_BUS_MSB: assert property (res_ff.supply[15] == 1'b0)
    else $error("bus result msb set");
  AST_BUS_PASS: assert property (meas_valid |=> res_ff.supply[14:0] == $past(meas.bus[14:0]))
    else $error("bus result not passed through");
  AST_CUR_CALC: assert property (meas_valid && cal_set_ff |=> res_ff.current == $past(cur_calc))
    else $error("current not refreshed");
  AST_PWR_CALC: assert property (meas_valid && cal_set_ff |=> res_ff.power == $past(pwr_calc))
    else $error("power not refreshed");
  AST_HOLD: assert property (!meas_valid |=> $stable(res_ff))
    else $error("results moved without measurement");
  AST_SENSE_PASS: assert property (meas_valid |=> res_ff.sense == $past(meas.shunt))
    else $error("sense result not passed through");
  AST_MSB_FIRST: assert property (rd_take && !rd_phase_ff |=> rd_byte == $past(sel_word[15:8]))
    else $error("upper byte not sent first");
  AST_LSB_SECOND: assert property (rd_take && rd_phase_ff |=> rd_byte == $past(sel_word[7:0]))
    else $error("lower byte not sent second");
  AST_CAL_WORD: assert property (wr_cal |=> cal_ff == {$past(wr_hi_ff), $past(wr_byte)} && cal_set_ff)
    else $error("calibration word misassembled");
  AST_CFG_RESET: assert property ($past(rst) |-> cfg_word == `CPCE_CONFIG_RST)
    else $error("config not at default after reset");
  // register port framing
  AST_PTR_WINS: assert property (ptr_load |=> ptr_ff == $past(ptr_byte) && !wr_phase_ff && !rd_phase_ff)
    else $error("pointer load did not restart byte phases");
  AST_RD_HOLD: assert property (!rd_take |=> $stable(rd_byte))
    else $error("read byte moved without a read");
  AST_WR_DROP: assert property (wr_commit && !wr_cfg && !wr_cal |=> $stable(cfg_ff) && $stable(cal_ff))
    else $error("write to read-only word landed");
  AST_CLASH_DROP: assert property (ptr_load && wr_stb |=> $stable(cfg_ff) && $stable(cal_ff))
    else $error("write byte beside pointer load committed");

  // covers: the scenarios worth seeing in a run

  COV_CAL_WRITE: cover property (wr_cal);
  COV_CALC: cover property (wr_cal ##[1:20] meas_valid);
  COV_READ_WORD: cover property (rd_take && !rd_phase_ff ##[1:10] rd_take && rd_phase_ff);
  COV_NEG_CURRENT: cover property (meas_valid && cal_set_ff && meas.shunt[15]);
  COV_PTR_CLASH: cover property (ptr_load && wr_stb);

endmodule

// ===== logic/cpce_pkg.sv
// types shared by the power calc engine
package cpce_pkg;

  // one conversion result handed over by the converter
  typedef struct packed {
    logic [15:0] shunt; // signed sense voltage, 2.5 uV per count
    logic [15:0] bus;   // supply voltage, 1.25 mV per count
  } cpce_meas_t;

  // the four result words held by the engine
  typedef struct packed {
    logic [15:0] sense;
    logic [15:0] supply;
    logic [15:0] power;
    logic [15:0] current;
  } cpce_result_t;

endpackage

// ===== logic/cpce_regs.svh
// register offsets, reset values and arithmetic constants of the power calc engine
// ----------------------------------------------------------------------------
// How it works
// - only shunt and bus voltages are measured
// - current is shunt times calibration over 2048
// - power is current times bus over 20000
// - power count weighs 25 current counts
// - bus result fixed 1.25 mV per count
// - bus result top bit always zero
// - current and power zero until calibrated
// - calibrated: results refresh on every measurement
// - unprogrammed device still converts both voltages
// - words move most significant byte first
// ----------------------------------------------------------------------------
`ifndef CPCE_REGS_SVH
`define CPCE_REGS_SVH

// ----------------------------------------------------------------------------
// register pointers
// ----------------------------------------------------------------------------
`define CPCE_PTR_CONFIG 8'h00
`define CPCE_PTR_SENSE 8'h01
`define CPCE_PTR_SUPPLY 8'h02
`define CPCE_PTR_POWER 8'h03
`define CPCE_PTR_CURRENT 8'h04
`define CPCE_PTR_CAL 8'h05

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CPCE_CONFIG_RST 16'h0000
`define CPCE_WORD_RST 16'h0000

// ----------------------------------------------------------------------------
// arithmetic divisors, sized for the products they meet
// ----------------------------------------------------------------------------
`define CPCE_CUR_DIV 33'sh0800
`define CPCE_PWR_DIV 33'sh4E20

`endif

// ===== verif/cpce_host_model.sv
// host model driving the byte-level register port
`timescale 1ns/1ps

module cpce_host_model (
  input wire logic mclk,
  input wire logic [7:0] rd_byte,
  output logic ptr_load,
  output logic [7:0] ptr_byte,
  output logic wr_stb,
  output logic [7:0] wr_byte,
  output logic rd_stb
);
  // idle port until the bench asks for a transfer
  initial begin
    ptr_load = 1'b0;
    ptr_byte = 8'h00;
    wr_stb = 1'b0;
    wr_byte = 8'h00;
    rd_stb = 1'b0;
  end

  task automatic put_word(input logic [7:0] p, input logic [15:0] w);
    @(posedge mclk);
    ptr_load <= 1'b1;
    ptr_byte <= p;
    @(posedge mclk);
    ptr_load <= 1'b0;
    ptr_byte <= ~p;
    wr_stb <= 1'b1;
    wr_byte <= w[15:8];
    @(posedge mclk);
    wr_byte <= w[7:0];
    @(posedge mclk);
    wr_stb <= 1'b0;
    wr_byte <= ~w[7:0]; // released lines show junk, not the last byte
    @(posedge mclk);
  endtask

  task automatic get_word(input logic [7:0] p, output logic [15:0] w);
    @(posedge mclk);
    ptr_load <= 1'b1;
    ptr_byte <= p;
    @(posedge mclk);
    ptr_load <= 1'b0;
    ptr_byte <= ~p;
    rd_stb <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    w[15:8] = rd_byte;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    w[7:0] = rd_byte;
  endtask

  // pointer kept: read the same word again with no pointer load
  task automatic get_again(output logic [15:0] w);
    @(posedge mclk);
    rd_stb <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    w[15:8] = rd_byte;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    w[7:0] = rd_byte;
  endtask

  // second byte beside a pointer load: the pointer wins, nothing commits
  task automatic put_cut(input logic [7:0] p, input logic [15:0] w);
    @(posedge mclk);
    ptr_load <= 1'b1;
    ptr_byte <= p;
    @(posedge mclk);
    ptr_load <= 1'b0;
    wr_stb <= 1'b1;
    wr_byte <= w[15:8];
    @(posedge mclk);
    ptr_load <= 1'b1;
    wr_byte <= w[7:0];
    @(posedge mclk);
    ptr_load <= 1'b0;
    ptr_byte <= ~p;
    wr_stb <= 1'b0;
    wr_byte <= ~w[7:0];
    @(posedge mclk);
  endtask

  // step rounded up to whole mA, cal = 0.00512/(step*r)
  function automatic logic [15:0] cal_for(input longint max_ua, input longint r_uohm);
    longint step_ua;
    step_ua = ((max_ua + 32767) / 32768 + 999) / 1000 * 1000;
    return 16'(64'sd5120000000 / (step_ua * r_uohm));
  endfunction

  function automatic logic [15:0] trim_cal(input longint cal, input longint meas, input longint dev);
    return 16'(cal * meas / dev);
  endfunction
endmodule

// ===== verif/tb_current_power_calc_engine.sv
// self-checking bench for the power calc engine
`timescale 1ns/1ps

module tb_current_power_calc_engine;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic meas_valid = 1'b0;
  cpce_pkg::cpce_meas_t meas = '0;
  logic ptr_load, wr_stb, rd_stb;
  logic [7:0] ptr_byte, wr_byte, rd_byte;
  logic [15:0] cfg_word, cal;
  int err_total = 0;
  int cmp_count = 0;

  always #12.5 mclk = ~mclk;

  cpce_engine dut (.mclk(mclk), .rst(rst), .meas_valid(meas_valid), .meas(meas), .ptr_load(ptr_load),
    .ptr_byte(ptr_byte), .wr_stb(wr_stb), .wr_byte(wr_byte), .rd_stb(rd_stb), .rd_byte(rd_byte),
    .cfg_word(cfg_word));
  cpce_host_model host (.mclk(mclk), .rd_byte(rd_byte), .ptr_load(ptr_load), .ptr_byte(ptr_byte),
    .wr_stb(wr_stb), .wr_byte(wr_byte), .rd_stb(rd_stb));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // reference arithmetic, truncating toward zero
  function automatic logic [15:0] exp_cur(input logic [15:0] sh, input logic [15:0] c);
    return 16'(longint'($signed(sh)) * longint'(c) / 2048);
  endfunction
  function automatic logic [15:0] exp_pwr(input logic [15:0] cu, input logic [15:0] b);
    return 16'(longint'($signed(cu)) * longint'({1'b0, b[14:0]}) / 20000);
  endfunction

  task automatic meas_put(input logic [15:0] sh, input logic [15:0] b);
    @(posedge mclk);
    meas_valid <= 1'b1;
    meas <= {sh, b};
    @(posedge mclk);
    meas_valid <= 1'b0;
    meas <= ~{sh, b};
  endtask

  task automatic read_chk(input logic [7:0] p, input logic [15:0] exp);
    logic [15:0] w;
    host.get_word(p, w);
    check(w, exp);
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic sc_reset;
    for (int p = 0; p < 8; p++) read_chk(8'(p), 16'h0000);
    check(cfg_word, 16'h0000);
  endtask

  task automatic sc_uncal;
    meas_put(16'h1F40, 16'h2570);
    read_chk(8'h01, 16'h1F40);
    read_chk(8'h02, 16'h2570);
    read_chk(8'h04, 16'h0000);
    read_chk(8'h03, 16'h0000);
  endtask

  task automatic sc_cal;
    cal = host.cal_for(64'd15000000, 64'd2000);
    host.put_word(8'h05, cal);
    read_chk(8'h05, 16'h0A00);
    meas_put(16'h1F40, 16'h2570);
    read_chk(8'h04, 16'h2710);
    read_chk(8'h03, 16'h12B8);
    host.put_word(8'h04, 16'h1234); // read-only, must be dropped
    read_chk(8'h04, 16'h2710);
    host.put_word(8'h00, 16'h4127);
    check(cfg_word, 16'h4127);
  endtask

  task automatic sc_table;
    logic [15:0] sh [3] = '{16'h0003, 16'hE0C0, 16'h7FFF};
    logic [15:0] bv [3] = '{16'h2570, 16'hFFFF, 16'h8001};
    for (int i = 0; i < 3; i++) begin
      meas_put(sh[i], bv[i]);
      read_chk(8'h02, {1'b0, bv[i][14:0]});
      read_chk(8'h04, exp_cur(sh[i], cal));
      read_chk(8'h03, exp_pwr(exp_cur(sh[i], cal), bv[i]));
    end
  endtask

  task automatic sc_b2b_trim;
    @(posedge mclk);
    meas_valid <= 1'b1;
    meas <= {16'h0100, 16'h0200};
    @(posedge mclk);
    meas <= {16'h1F40, 16'h2570};
    @(posedge mclk);
    meas_valid <= 1'b0;
    read_chk(8'h04, 16'h2710);
    cal = host.trim_cal(64'(cal), 64'd9900, 64'd10000);
    host.put_word(8'h05, cal);
    meas_put(16'h1F40, 16'h2570);
    read_chk(8'h04, exp_cur(16'h1F40, cal));
  endtask

  task automatic sc_port;
    logic [15:0] w;
    host.put_cut(8'h05, 16'hFFFF);
    read_chk(8'h05, cal);
    read_chk(8'h04, exp_cur(16'h1F40, cal));
    host.get_again(w);
    check(w, exp_cur(16'h1F40, cal));
  endtask

  // watchdog against a hung run
  initial begin
    repeat (100000) @(posedge mclk);
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    sc_reset();
    sc_uncal();
    sc_cal();
    sc_table();
    sc_b2b_trim();
    sc_port();
    give_verdict();
  end
endmodule
